// ---- verilog/fg_pkg.sv ----
// fuel gauge register bank: shared constants, carrier structs and state types
// assumes a 250 MHz system clock and an external word-level front end for the serial bus
package fg_pkg;

    // ----------------------------------------------------------------
    // clock and time base
    // ----------------------------------------------------------------
    localparam int FG_CLK_MHZ = 250;                    // system clock rate
    localparam int FG_TICK_TIME_US = 1000;              // gauge time step, 1 ms
    localparam int FG_TICK_CYCLES = FG_TICK_TIME_US * FG_CLK_MHZ;
    localparam int FG_TICK_W = 20;                      // divider counter width
    localparam int FG_CNT_W = 12;                       // millisecond counters
    localparam int FG_FIRST_CONV_MS = 125;              // averaging after reset
    localparam int FG_CONV_MS = 500;                    // averaging per cycle
    localparam int FG_IDLE_SLEEP_MS = 2500;             // bus low time to sleep

    // ----------------------------------------------------------------
    // register map and command values
    // ----------------------------------------------------------------
    localparam logic [7:0] FG_ADDR_VOLTAGE = 8'h02;
    localparam logic [7:0] FG_ADDR_CHARGE = 8'h04;
    localparam logic [7:0] FG_ADDR_MODE = 8'h06;
    localparam logic [7:0] FG_ADDR_REVISION = 8'h08;
    localparam logic [7:0] FG_ADDR_CONFIG = 8'h0C;
    localparam logic [7:0] FG_ADDR_COMMAND = 8'hFE;
    localparam logic [15:0] FG_MODE_QUICK_START = 16'h4000;
    localparam logic [15:0] FG_CMD_FULL_RESET = 16'h0054;
    localparam logic [15:0] FG_CFG_RESET = 16'h971C;
    localparam logic [15:0] FG_READ_ZERO = 16'h0000;
    localparam logic [4:0] FG_ACC_BITS = 5'h10;         // full word transfer
    localparam logic [3:0] FG_VOLT_PAD = 4'h0;          // 12-bit result sits in 15:4
    localparam logic [5:0] FG_ALERT_THRESHOLD_BASE = 6'h20;        // threshold = 32 - field
    localparam logic [15:0] FG_CHARGE_MAX = 16'hFFFF;
    localparam logic [15:0] FG_CHARGE_MIN = 16'h0000;
    localparam int FG_STEP_1S_UV10 = 125;               // 1.25 mV step, single cell
    localparam int FG_STEP_2S_UV10 = 250;               // 2.50 mV step, two cells

    // ----------------------------------------------------------------
    // carriers and state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] model_comp;     // model_compensation
        logic sleep;                // bit 7, software sleep
        logic dont_care;            // bit 6, unwritable
        logic alert_flag;           // bit 5
        logic [4:0] alert_threshold;           // alert_threshold, complement coded
    } fg_cfg_t;

    typedef struct packed {
        logic write;                // 1 write, 0 read
        logic [7:0] addr;           // register byte address
        logic [15:0] wdata;         // write word
        logic [4:0] bits;           // bits actually transferred
    } fg_acc_t;

    typedef struct packed {
        logic [FG_TICK_W-1:0] cnt;
        logic tick;
    } fg_tick_st_t;

    typedef struct packed {
        logic [FG_CNT_W-1:0] cnt;
        logic scl_q;
        logic sda_q;
        logic fired;
        logic fire;
        logic wake;
    } fg_idle_st_t;

    typedef struct packed {
        fg_cfg_t cfg;
        logic [15:0] voltage;
        logic [15:0] charge;
        logic charge_valid;         // a charge value has been loaded
        logic armed;                // alert may fire
        logic first_conv;           // next conversion is the short one
        logic [FG_CNT_W-1:0] period;
        logic bus_sleep;
        logic qs_q;
        logic [15:0] rd_data;
        logic restart;
        logic conv_done;
        logic estimate;
        logic no_ack;
    } fg_st_t;

    // clamp a signed model result into the register range
    function automatic logic [15:0] fg_sat(input logic signed [17:0] v);
        logic [15:0] r;
        r = v[15:0];
        if (v < 18'sh0_0000) begin
            r = FG_CHARGE_MIN;
        end else if (v > 18'sh0_FFFF) begin
            r = FG_CHARGE_MAX;
        end
        return r;
    endfunction

endpackage

// ---- verilog/fg_tick.sv ----
// fuel gauge millisecond enable divider
// assumes one system clock; run_in low freezes the phase (sleep)
`timescale 1ns/10ps
module fg_tick #(
    parameter int TICK_CYCLES = fg_pkg::FG_TICK_CYCLES
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    // control
    input wire logic clear_in,
    input wire logic run_in,
    // enable
    output logic tick_out
);
    import fg_pkg::*;

    // ----------------------------------------------------------------
    // elaboration check
    // ----------------------------------------------------------------
    if (TICK_CYCLES < 2 || TICK_CYCLES >= (1 << FG_TICK_W)) begin : g_bad_tick
        $error("fg_tick: TICK_CYCLES out of range");
    end

    localparam logic [FG_TICK_W-1:0] LAST = FG_TICK_W'(TICK_CYCLES - 1);

    fg_tick_st_t st_r;
    fg_tick_st_t st_nxt;

    // divider next state, one pulse per wrap
    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (clear_in) begin
            st_nxt.cnt = '0;                        // restart phase with gauge
        end else if (run_in) begin
            if (st_r.cnt == LAST) begin
                st_nxt.cnt = '0;
                st_nxt.tick = 1'b1;
            end else begin
                st_nxt.cnt = st_r.cnt + 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick_out = st_r.tick;

endmodule

// ---- verilog/fg_idle.sv ----
// fuel gauge bus idle watcher: long low on both lines, and wake edges
// assumes bus line levels already synchronous; tick_in stops while asleep
`timescale 1ns/10ps
module fg_idle (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    // time base and lines
    input wire logic tick_in,
    input wire logic scl_level_in,
    input wire logic sda_level_in,
    // events
    output logic idle_sleep_out,
    output logic wake_edge_out
);
    import fg_pkg::*;

    localparam logic [FG_CNT_W-1:0] IDLE_LAST = FG_CNT_W'(FG_IDLE_SLEEP_MS - 1);

    fg_idle_st_t st_r;
    fg_idle_st_t st_nxt;
    logic both_low;

    // idle counter and edge detect
    always_comb begin
        both_low = !scl_level_in && !sda_level_in;
        st_nxt = st_r;
        st_nxt.scl_q = scl_level_in;
        st_nxt.sda_q = sda_level_in;
        st_nxt.fire = 1'b0;
        st_nxt.wake = (scl_level_in && !st_r.scl_q) || (sda_level_in && !st_r.sda_q);
        if (!both_low) begin
            st_nxt.cnt = '0;                        // any high level restarts timing
            st_nxt.fired = 1'b0;
        end else if (tick_in && !st_r.fired) begin
            if (st_r.cnt == IDLE_LAST) begin
                st_nxt.fire = 1'b1;                 // one request per low stretch
                st_nxt.fired = 1'b1;
            end else begin
                st_nxt.cnt = st_r.cnt + 1'b1;
            end
        end
    end

    // state register; lines idle high after reset
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_r <= '{cnt: '0, scl_q: 1'b1, sda_q: 1'b1, fired: 1'b0, fire: 1'b0, wake: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign idle_sleep_out = st_r.fire;
    assign wake_edge_out = st_r.wake;

endmodule

// ---- verilog/fg_regs.sv ----
// fuel gauge host register bank: voltage and charge results, commands, alert, sleep
// assumes a serial front end that hands over whole register accesses with a bit count,
// an analogue converter giving a 12-bit average, and a model giving charge results
//
// How it works
// - first conversion yields initial charge estimate
// - quick-start pin edge or 4000h restarts gauge
// - only 4000h in mode register acts
// - alert when charge falls below threshold
// - alert drives pin low, sets flag
// - pin stays low until flag cleared
// - re-arm only after rising above threshold, or on quick-start or full reset
// - alert comparison live once a charge is loaded
// - sleep keeps pending alert intact
// - both lines low long enough means sleep
// - bus edge wakes, gauging resumes
// - sleep bit sleeps until written zero
// - 0054h command fully resets, no acknowledge
// - only complete 16-bit writes commit
// - only listed register pairs decode
// - 125 ms first average, then 500 ms
// - after sleep, full period before update
// - 12-bit voltage, cell-dependent step
// - charge high byte percent, low 1/256
// - first charge update within 250 ms
// - out-of-range charge saturates
// - configuration resets to 971Ch
// - threshold complement coded, reset 1Ch
// - sleep bit resets to zero
// - bit 6 ignores writes
`timescale 1ns/10ps
module fg_regs #(
    parameter int MS_TICK_CYCLES = fg_pkg::FG_TICK_CYCLES,  // cycles per 1 ms step
    parameter logic [15:0] REVISION = 16'h0001,             // arbitrary revision value
    parameter bit TWO_CELL = 1'b0                           // two-cell pack variant
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    // register access from the serial front end
    input wire logic acc_stb_in,
    input wire fg_pkg::fg_acc_t acc_in,
    output logic [15:0] rd_data_out,
    output logic no_ack_out,
    // pins
    input wire logic restart_estimate_pin_in,
    input wire logic scl_level_in,
    input wire logic sda_level_in,
    output logic low_charge_alert_n_out,
    // converter and model side
    input wire logic [11:0] adc_voltage_in,
    input wire logic [15:0] est_charge_in,
    input wire logic charge_calc_stb_in,
    input wire logic signed [17:0] charge_calc_in,
    output logic [7:0] model_compensation_out,
    output logic conv_done_out,
    output logic restart_out,
    output logic estimate_out,
    output logic [15:0] volt_step_uv10_out,
    output logic asleep_out
);
    import fg_pkg::*;

    // ----------------------------------------------------------------
    // constants and elaboration checks
    // ----------------------------------------------------------------
    if (MS_TICK_CYCLES < 2) begin : g_bad_tick
        $error("fg_regs: MS_TICK_CYCLES must be at least 2");
    end

    localparam logic [FG_CNT_W-1:0] FIRST_LAST = FG_CNT_W'(FG_FIRST_CONV_MS - 1);
    localparam logic [FG_CNT_W-1:0] CONV_LAST = FG_CNT_W'(FG_CONV_MS - 1);
    localparam logic [15:0] VOLT_STEP = TWO_CELL ? 16'(FG_STEP_2S_UV10) : 16'(FG_STEP_1S_UV10);

    // power-on image of all state
    localparam fg_st_t ST_RESET = '{
        cfg: fg_cfg_t'(FG_CFG_RESET),
        voltage: 16'h0000,
        charge: 16'h0000,
        charge_valid: 1'b0,
        armed: 1'b1,
        first_conv: 1'b1,
        period: '0,
        bus_sleep: 1'b0,
        qs_q: 1'b0,
        rd_data: 16'h0000,
        restart: 1'b0,
        conv_done: 1'b0,
        estimate: 1'b0,
        no_ack: 1'b0
    };

    // ----------------------------------------------------------------
    // state and helpers
    // ----------------------------------------------------------------
    fg_st_t st_r;
    fg_st_t st_nxt;
    logic tick;             // 1 ms enable, halted while asleep
    logic idle_fire;        // bus held low long enough
    logic wake_edge;        // rising edge on either line
    logic asleep;           // any sleep source active
    logic commit;           // complete write this cycle
    logic wr_mode;
    logic wr_cfg;
    logic wr_cmd;
    logic do_quick;
    logic do_full;
    logic [5:0] thr_pct;    // threshold in whole percent
    logic below;            // charge under threshold
    logic [FG_CNT_W-1:0] period_last;
    fg_cfg_t wcfg;

    assign asleep = st_r.cfg.sleep || st_r.bus_sleep;

    // ----------------------------------------------------------------
    // time base and bus idle watcher
    // ----------------------------------------------------------------
    fg_tick #(
        .TICK_CYCLES(MS_TICK_CYCLES)
    ) u_tick (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .clear_in(st_r.restart),
        .run_in(!asleep),
        .tick_out(tick)
    );

    fg_idle u_idle (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .tick_in(tick),
        .scl_level_in(scl_level_in),
        .sda_level_in(sda_level_in),
        .idle_sleep_out(idle_fire),
        .wake_edge_out(wake_edge)
    );

    // ----------------------------------------------------------------
    // access decode
    // ----------------------------------------------------------------
    always_comb begin
        // partial writes never reach a register
        commit = acc_stb_in && acc_in.write && (acc_in.bits == FG_ACC_BITS);
        wr_mode = commit && (acc_in.addr == FG_ADDR_MODE);
        wr_cfg = commit && (acc_in.addr == FG_ADDR_CONFIG);
        wr_cmd = commit && (acc_in.addr == FG_ADDR_COMMAND);
        do_quick = (wr_mode && (acc_in.wdata == FG_MODE_QUICK_START)) ||
                   (restart_estimate_pin_in && !st_r.qs_q);
        do_full = wr_cmd && (acc_in.wdata == FG_CMD_FULL_RESET);
        wcfg = fg_cfg_t'(acc_in.wdata);
        // complement code: 00000 is 32 %, 11111 is 1 %
        thr_pct = FG_ALERT_THRESHOLD_BASE - {1'b0, st_r.cfg.alert_threshold};
        below = st_r.charge_valid && ({2'b00, st_r.charge[15:8]} < thr_pct);
        period_last = st_r.first_conv ? FIRST_LAST : CONV_LAST;
    end

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.restart = 1'b0;
        st_nxt.conv_done = 1'b0;
        st_nxt.estimate = 1'b0;
        st_nxt.no_ack = 1'b0;
        st_nxt.qs_q = restart_estimate_pin_in;

        // read port: unlisted and write-only addresses answer zero
        if (acc_stb_in && !acc_in.write) begin
            case (acc_in.addr)
                FG_ADDR_VOLTAGE: begin
                    st_nxt.rd_data = st_r.voltage;
                end
                FG_ADDR_CHARGE: begin
                    st_nxt.rd_data = st_r.charge;
                end
                FG_ADDR_REVISION: begin
                    st_nxt.rd_data = REVISION;
                end
                FG_ADDR_CONFIG: begin
                    st_nxt.rd_data = st_r.cfg;
                end
                default: begin
                    st_nxt.rd_data = FG_READ_ZERO;
                end
            endcase
        end

        // configuration write; flag can only be cleared, bit 6 is fixed
        if (wr_cfg) begin
            st_nxt.cfg.model_comp = wcfg.model_comp;
            st_nxt.cfg.sleep = wcfg.sleep;
            st_nxt.cfg.alert_threshold = wcfg.alert_threshold;
            st_nxt.cfg.alert_flag = st_r.cfg.alert_flag && wcfg.alert_flag;
            st_nxt.cfg.dont_care = st_r.cfg.dont_care;
            // writing the bit to zero also ends any bus-idle sleep
            if (!wcfg.sleep) begin
                st_nxt.bus_sleep = 1'b0;
            end
        end

        // idle bus sleep; edges only wake when software did not ask for sleep
        if (idle_fire && !st_r.cfg.sleep) begin
            st_nxt.bus_sleep = 1'b1;
        end else if (wake_edge && st_r.bus_sleep) begin
            st_nxt.bus_sleep = 1'b0;
        end

        // leaving sleep: wait a whole period, short or long per first_conv, before a new voltage
        if (asleep && !(st_nxt.cfg.sleep || st_nxt.bus_sleep)) begin
            st_nxt.period = '0;
        end

        // conversion timing; everything halts while asleep
        if (tick && !asleep) begin
            if (st_r.period == period_last) begin
                st_nxt.period = '0;
                st_nxt.voltage = {adc_voltage_in, FG_VOLT_PAD};
                st_nxt.conv_done = 1'b1;
                st_nxt.first_conv = 1'b0;
                // first conversion after reset seeds the charge estimate
                if (st_r.first_conv) begin
                    st_nxt.charge = est_charge_in;
                    st_nxt.charge_valid = 1'b1;
                    st_nxt.estimate = 1'b1;
                end
            end else begin
                st_nxt.period = st_r.period + 1'b1;
            end
        end

        // later model results, clamped into range
        if (charge_calc_stb_in && !asleep && st_r.charge_valid) begin
            st_nxt.charge = fg_sat(charge_calc_in);
        end

        // alert: set wins over a clear in the same cycle; sleep does not touch it
        if (below && st_r.armed) begin
            st_nxt.cfg.alert_flag = 1'b1;
            st_nxt.armed = 1'b0;
        end else if (!below && st_r.charge_valid) begin
            st_nxt.armed = 1'b1;
        end

        // quick-start: restart gauging like power-up, keep configuration
        if (do_quick) begin
            st_nxt.first_conv = 1'b1;
            st_nxt.period = '0;
            st_nxt.charge_valid = 1'b0;
            st_nxt.armed = 1'b1;
            st_nxt.restart = 1'b1;
        end

        // full reset: back to the power-on image, transfer left unacknowledged
        if (do_full) begin
            st_nxt = ST_RESET;
            st_nxt.qs_q = restart_estimate_pin_in;
            st_nxt.restart = 1'b1;
            st_nxt.no_ack = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_r <= ST_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign rd_data_out = st_r.rd_data;
    assign no_ack_out = st_r.no_ack;
    assign low_charge_alert_n_out = !st_r.cfg.alert_flag;
    assign model_compensation_out = st_r.cfg.model_comp;
    assign conv_done_out = st_r.conv_done;
    assign restart_out = st_r.restart;
    assign estimate_out = st_r.estimate;
    assign volt_step_uv10_out = VOLT_STEP;
    assign asleep_out = asleep;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (sys_rst_in);

    alert_cause_a: assert property ($rose(st_r.cfg.alert_flag) |-> $past(below) && $past(st_r.armed))
        else $error("alert flag rose without cause");
    alert_hold_a: assert property (st_r.cfg.alert_flag && !wr_cfg && !do_full |=> !low_charge_alert_n_out)
        else $error("alert pin released without clear");
    no_rearm_a: assert property (!st_r.armed && below && !do_quick && !do_full |=> !st_r.armed)
        else $error("alert re-armed while below threshold");
    quick_start_a: assert property (wr_mode && acc_in.wdata == FG_MODE_QUICK_START
                                    |=> st_r.restart && st_r.first_conv && st_r.period == '0)
        else $error("quick-start not taken");
    mode_reserved_a: assert property (wr_mode && acc_in.wdata != FG_MODE_QUICK_START
                                      && !(restart_estimate_pin_in && !st_r.qs_q) && !do_full |=> !st_r.restart)
        else $error("reserved mode value acted");
    full_reset_a: assert property (do_full |=> st_r.cfg == fg_cfg_t'(FG_CFG_RESET) && st_r.no_ack
                                   ##1 (!st_r.no_ack || $past(do_full)))
        else $error("full reset command misbehaved");
    partial_write_a: assert property (acc_stb_in && acc_in.write && acc_in.bits != FG_ACC_BITS
                                      && !(restart_estimate_pin_in && !st_r.qs_q) && !below
                                      |=> $stable(st_r.cfg))
        else $error("partial write changed configuration");
    // a clear carried by the same write is legal; only the sleep entry itself must not release
    sleep_alert_a: assert property ($rose(asleep) && !$past(wr_cfg && !wcfg.alert_flag) |->
                                    !$rose(low_charge_alert_n_out))
        else $error("sleep entry changed alert");
    soft_sleep_a: assert property (st_r.cfg.sleep && !wr_cfg && !do_full |=> asleep)
        else $error("software sleep ended without a write");
    sleep_hold_a: assert property (asleep && $past(asleep) && !do_full |-> $stable(st_r.voltage))
        else $error("voltage changed during sleep");
    wake_period_a: assert property ($fell(asleep) && !$past(do_quick) && !$past(do_full) |-> st_r.period == '0)
        else $error("period not restarted on wake");

    quick_cover_c: cover property (do_quick ##[1:10] st_r.restart);
    alert_cover_c: cover property ($rose(st_r.cfg.alert_flag) ##[1:50] $fell(st_r.cfg.alert_flag));
    wake_cover_c: cover property ($rose(st_r.bus_sleep) ##[1:50] $fell(st_r.bus_sleep));
    conv_cover_c: cover property (st_r.estimate ##[1:1000] st_r.conv_done);

endmodule

// ---- verification/fg_host_model.sv ----
// host stand-in: issues whole register words and drives the two bus line levels
// assumes the device samples every input on the rising edge of clk_sys_in
`timescale 1ns/10ps
module fg_host_model (
    // clock
    input wire logic clk_sys_in,
    // register access towards the device
    output logic acc_stb_out,
    output fg_pkg::fg_acc_t acc_out,
    // bus line levels, pulled up while released
    output logic scl_level_out,
    output logic sda_level_out
);
    import fg_pkg::*;
    // -------------------------------------------------------------
    // idle state
    // -------------------------------------------------------------
    initial begin
        acc_stb_out = 1'b0;
        acc_out = '0;
        scl_level_out = 1'b1;
        sda_level_out = 1'b1;
    end
    // one strobe carries a word, held across the sampling edge
    task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] d, input logic [4:0] nb);
        @(posedge clk_sys_in);
        #1;
        acc_stb_out = 1'b1;
        acc_out = '{write: wr, addr: a, wdata: d, bits: nb};
        @(posedge clk_sys_in);
        #1;
        acc_stb_out = 1'b0;
        // released word is scrambled so stale data cannot pass for fresh
        acc_out.wdata = ~d;
    endtask
    // both lines low for n cycles, then a rising edge on both
    task automatic line_edge(input int n);
        @(posedge clk_sys_in);
        #1;
        scl_level_out = 1'b0;
        sda_level_out = 1'b0;
        repeat (n) @(posedge clk_sys_in);
        #1;
        scl_level_out = 1'b1;
        sda_level_out = 1'b1;
        repeat (4) @(posedge clk_sys_in);
        #1;
    endtask
endmodule

// ---- verification/testbench.sv ----
// self-checking bench for the fuel gauge register bank
// assumes fg_host_model on the access side and a 20-cycle gauge step
`timescale 1ns/10ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
    import fg_pkg::*;
    logic clk_sys_in, sys_rst_in, stb, scl, sda, pin, calc_stb, alert_n, no_ack, restart, conv, asleep, est_p;
    logic [7:0] mc;
    fg_acc_t acc;
    logic [11:0] adc;
    logic [15:0] est, rd, step;
    logic signed [17:0] calc;
    int errors = 0;
    int check_count = 0;
    int since, n;
    fg_host_model host_inst (.clk_sys_in(clk_sys_in), .acc_stb_out(stb), .acc_out(acc),
        .scl_level_out(scl), .sda_level_out(sda));
    fg_regs #(.MS_TICK_CYCLES(20)) fg_regs_inst (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
        .acc_stb_in(stb), .acc_in(acc), .rd_data_out(rd), .no_ack_out(no_ack),
        .restart_estimate_pin_in(pin), .scl_level_in(scl), .sda_level_in(sda),
        .low_charge_alert_n_out(alert_n), .adc_voltage_in(adc), .est_charge_in(est),
        .charge_calc_stb_in(calc_stb), .charge_calc_in(calc), .model_compensation_out(mc),
        .conv_done_out(conv), .restart_out(restart), .estimate_out(est_p), .volt_step_uv10_out(step),
        .asleep_out(asleep));
    // cycles since reset release, for conversion timing
    always @(posedge clk_sys_in) since <= sys_rst_in ? 0 : since + 1;
    task automatic rdreg(input logic [7:0] a, input logic [15:0] e);
        host_inst.access(1'b0, a, 16'h0000, 5'h10);
        `CHK(rd, e)
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        host_inst.access(1'b1, a, d, 5'h10);
    endtask
    // model result strobe; flag settles two edges later
    task automatic calc_in(input logic signed [17:0] v);
        @(posedge clk_sys_in);
        #1;
        calc = v;
        calc_stb = 1'b1;
        @(posedge clk_sys_in);
        #1;
        calc_stb = 1'b0;
        repeat (2) @(posedge clk_sys_in);
        #1;
    endtask
    // -------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------
    task automatic s_reset();
        rdreg(8'h0C, 16'h971C);
        rdreg(8'h0A, 16'h0000);
        `CHK(alert_n, 1'b1)
        `CHK(mc, 8'h97)
        `CHK(asleep, 1'b0)
        `CHK(step, 16'h007D)
        host_inst.access(1'b1, 8'h0C, 16'h0000, 5'h0F);
        rdreg(8'h0C, 16'h971C);
    endtask
    task automatic s_conv();
        n = 0;
        while (conv !== 1'b1 && n < 3000) begin
            @(posedge clk_sys_in);
            #1;
            n++;
        end
        `CHK(since inside {[2500:2504]}, 1'b1)
        `CHK(est_p, 1'b1)
        repeat (2) @(posedge clk_sys_in);
        #1;
        rdreg(8'h02, 16'hABC0);
        rdreg(8'h04, 16'h0280);
        `CHK(alert_n, 1'b0)
        rdreg(8'h0C, 16'h973C);
    endtask
    task automatic s_sleep();
        wr(8'h0C, 16'h97BC);
        `CHK(asleep, 1'b1)
        `CHK(alert_n, 1'b0)
        host_inst.line_edge(4);
        `CHK(asleep, 1'b1)
        wr(8'h0C, 16'h973C);
        `CHK(asleep, 1'b0)
    endtask
    // 2500 ms of 20-cycle steps is about 50000 cycles of low lines
    task automatic s_idle();
        fork
            host_inst.line_edge(50100);
            begin
                repeat (49000) @(posedge clk_sys_in);
                #1;
                `CHK(asleep, 1'b0)
                repeat (1050) @(posedge clk_sys_in);
                #1;
                `CHK(asleep, 1'b1)
                `CHK(alert_n, 1'b0)
            end
        join
        `CHK(asleep, 1'b0)
    endtask
    task automatic s_rearm();
        wr(8'h0C, 16'h975C);
        `CHK(alert_n, 1'b1)
        rdreg(8'h0C, 16'h971C);
        calc_in(-18'sd5);
        rdreg(8'h04, 16'h0000);
        `CHK(alert_n, 1'b1)
        calc_in(18'sh00A00);
        calc_in(18'sh00100);
        `CHK(alert_n, 1'b0)
    endtask
    task automatic s_cmds();
        wr(8'h06, 16'h4001);
        `CHK(restart, 1'b0)
        wr(8'h06, 16'h4000);
        `CHK(restart, 1'b1)
        pin = 1'b1;
        n = 0;
        repeat (4) begin
            @(posedge clk_sys_in);
            #1;
            n += int'(restart === 1'b1);
        end
        `CHK(n, 1)
        wr(8'hFE, 16'h0054);
        `CHK(no_ack, 1'b1)
        rdreg(8'h0C, 16'h971C);
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        clk_sys_in = 1'b0;
        forever #2 clk_sys_in = ~clk_sys_in;
    end
    // watchdog well past the longest expected run
    initial begin
        #300000;
        errors++;
        final_report();
    end
    initial begin
        {sys_rst_in, pin, calc_stb, calc, adc, est} = {3'b100, 18'sd0, 12'hABC, 16'h0280};
        repeat (20) @(posedge clk_sys_in);
        #1;
        sys_rst_in = 1'b0;
        s_reset();
        s_conv();
        s_sleep();
        s_idle();
        s_rearm();
        s_cmds();
        final_report();
    end
endmodule
